// ### core/psg_gate.sv
// Suspend gate: SPI opcode capture, state gating and hold flags
`timescale 1ns/10ps
module psg_gate #(
   parameter int unsigned HALT_LAT_CYC =
      psg_pkg::HALT_LATENCY_US * psg_pkg::CLK_MHZ
) (
   // Clock and reset
   input  wire logic                CLK_I,
   input  wire logic                RST_N_I,
   // SPI pins
   input  wire logic                SPI_CS_N_I,
   input  wire logic                SPI_SCK_I,
   input  wire logic                SPI_SI_I,
   // Array engine
   input  wire logic                OP_DONE_I,
   input  wire logic                HALT_ACK_I,
   output logic                     CMD_START_O,
   output psg_pkg::psg_cmd_s        CMD_O,
   output logic                     CMD_REJECT_O,
   output logic                     HALT_REQ_O,
   output logic                     RESUME_O,
   output logic                     RESUME_ERASE_O,
   // Status
   output psg_pkg::psg_flags_s      STATUS_O
);

   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   localparam int CNT_W = $clog2(HALT_LAT_CYC + 1);

   logic                         cs_meta_q, cs_s_q, cs_prev_q;
   logic                         sck_meta_q, sck_s_q, sck_prev_q;
   logic                         si_meta_q, si_s_q;
   logic                         sck_rise, cs_rise, cs_fall;
   logic [2:0]                   bit_q;
   logic [2:0]                   byte_q;
   logic [6:0]                   shift_q;
   psg_pkg::psg_op_t             op_q;
   logic [psg_pkg::ADDR_W-1:0]   addr_q;
   psg_pkg::psg_op_t             byte_in;
   logic                         frame_ok;
   psg_pkg::psg_class_e          cls;
   logic                         have_addr, same_blk, same_page;
   logic                         allow, accept, idle;
   logic                         starts_op;
   psg_pkg::psg_run_e            run_new;
   psg_pkg::psg_run_e            run_q;
   logic [psg_pkg::ADDR_W-1:0]   run_addr_q;
   logic [psg_pkg::ADDR_W-1:0]   pgm_addr_q, ers_addr_q;
   logic                         halt_pend_q;
   logic [CNT_W-1:0]             halt_cnt_q;
   logic                         halt_done;
   logic                         busy_q, wl_q, ph_q, eh_q, sum_q;
   logic                         ph_d, eh_d;
   logic                         go_accept, halt_accept;

   // ------------------------------------------------------------
   // Opcode classes
   // ------------------------------------------------------------
   function automatic psg_pkg::psg_class_e classify(
      input psg_pkg::psg_op_t op);
      psg_pkg::psg_class_e c;
      c = psg_pkg::CL_OTHER;
      unique case (op)
         psg_pkg::OP_TERM, psg_pkg::OP_RSEN, psg_pkg::OP_RST,
         psg_pkg::OP_ID0, psg_pkg::OP_ID1, psg_pkg::OP_ID2,
         psg_pkg::OP_WAKE, psg_pkg::OP_ST0, psg_pkg::OP_ST1,
         psg_pkg::OP_ST2, psg_pkg::OP_ST3:
            c = psg_pkg::CL_ALWAYS;
         psg_pkg::OP_HL0, psg_pkg::OP_HL1:
            c = psg_pkg::CL_HALT;
         psg_pkg::OP_GO0, psg_pkg::OP_GO1:
            c = psg_pkg::CL_RESUME;
         psg_pkg::OP_RD0, psg_pkg::OP_RD1, psg_pkg::OP_RD2,
         psg_pkg::OP_RD3, psg_pkg::OP_RD4, psg_pkg::OP_RD5:
            c = psg_pkg::CL_READ;
         psg_pkg::OP_LKR0, psg_pkg::OP_LKR1, psg_pkg::OP_OTPR,
         psg_pkg::OP_SFDP, psg_pkg::OP_WRAP, psg_pkg::OP_VWL:
            c = psg_pkg::CL_HELDOK;
         psg_pkg::OP_WLSET, psg_pkg::OP_WLCLR:
            c = psg_pkg::CL_WLAT;
         psg_pkg::OP_PG0, psg_pkg::OP_PG1, psg_pkg::OP_PG2:
            c = psg_pkg::CL_PROG;
         psg_pkg::OP_SQ0, psg_pkg::OP_SQ1:
            c = psg_pkg::CL_SEQ;
         psg_pkg::OP_ER0, psg_pkg::OP_ER1, psg_pkg::OP_ER2:
            c = psg_pkg::CL_ERASE;
         psg_pkg::OP_CE0, psg_pkg::OP_CE1, psg_pkg::OP_OTPW:
            c = psg_pkg::CL_CHIP;
         psg_pkg::OP_SW0, psg_pkg::OP_SW1, psg_pkg::OP_SW2,
         psg_pkg::OP_SW3, psg_pkg::OP_STLK, psg_pkg::OP_LK0,
         psg_pkg::OP_LK1, psg_pkg::OP_LK2, psg_pkg::OP_LK3:
            c = psg_pkg::CL_WRITE;
         psg_pkg::OP_DPD, psg_pkg::OP_UDPD:
            c = psg_pkg::CL_NEVER;
         default:
            c = psg_pkg::CL_OTHER;
      endcase
      return c;
   endfunction : classify

   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         cs_meta_q  <= 1'b1;
         cs_s_q     <= 1'b1;
         cs_prev_q  <= 1'b1;
         sck_meta_q <= 1'b0;
         sck_s_q    <= 1'b0;
         sck_prev_q <= 1'b0;
         si_meta_q  <= 1'b0;
         si_s_q     <= 1'b0;
      end else begin
         cs_meta_q  <= SPI_CS_N_I;
         cs_s_q     <= cs_meta_q;
         cs_prev_q  <= cs_s_q;
         sck_meta_q <= SPI_SCK_I;
         sck_s_q    <= sck_meta_q;
         sck_prev_q <= sck_s_q;
         si_meta_q  <= SPI_SI_I;
         si_s_q     <= si_meta_q;
      end
   end

   // Mode 0 idles low, so only rising edges inside a frame count
   assign sck_rise = sck_s_q & ~sck_prev_q & ~cs_s_q;
   assign cs_rise  = cs_s_q & ~cs_prev_q;
   assign cs_fall  = ~cs_s_q & cs_prev_q;
   assign byte_in  = {shift_q, si_s_q};

   // ------------------------------------------------------------
   // Opcode and address capture
   // ------------------------------------------------------------
   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         bit_q   <= 3'h0;
         byte_q  <= 3'h0;
         shift_q <= 7'h00;
      end else if (cs_fall) begin
         bit_q   <= 3'h0;
         byte_q  <= 3'h0;
      end else if (sck_rise) begin
         shift_q <= byte_in[6:0];
         bit_q   <= bit_q + 3'h1;
         if (bit_q == psg_pkg::BIT_LAST &&
             byte_q != psg_pkg::BYTES_ADDR) begin
            byte_q <= byte_q + 3'h1;
         end
      end
   end

   // Opcode MSB first, then three address bytes on the single line
   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         op_q   <= '0;
         addr_q <= '0;
      end else if (sck_rise && bit_q == psg_pkg::BIT_LAST) begin
         if (byte_q == 3'h0) begin
            op_q <= byte_in;
         end else if (byte_q != psg_pkg::BYTES_ADDR) begin
            addr_q <= {addr_q[psg_pkg::ADDR_W-9:0], byte_in};
         end
      end
   end

   // ------------------------------------------------------------
   // Gating decision at chip-select release
   // ------------------------------------------------------------
   assign frame_ok  = cs_rise & (bit_q == 3'h0) & (byte_q != 3'h0);
   assign cls       = classify(op_q);
   assign have_addr = (byte_q == psg_pkg::BYTES_ADDR);
   assign same_blk  = addr_q[psg_pkg::ADDR_W-1:psg_pkg::BLK_LSB] ==
                      ers_addr_q[psg_pkg::ADDR_W-1:psg_pkg::BLK_LSB];
   assign same_page = addr_q[psg_pkg::ADDR_W-1:psg_pkg::PAGE_LSB] ==
                      pgm_addr_q[psg_pkg::ADDR_W-1:psg_pkg::PAGE_LSB];
   assign idle      = ~busy_q & ~ph_q & ~eh_q;

   always_comb begin
      allow = 1'b0;
      unique case (cls)
         psg_pkg::CL_ALWAYS: allow = 1'b1;
         psg_pkg::CL_HALT:
            allow = busy_q & ~halt_pend_q &
                    (run_q == psg_pkg::RUN_PROG ||
                     run_q == psg_pkg::RUN_ERASE);
         psg_pkg::CL_RESUME: allow = ~busy_q & (ph_q | eh_q);
         psg_pkg::CL_READ,
         psg_pkg::CL_HELDOK,
         psg_pkg::CL_WLAT: allow = ~busy_q;
         psg_pkg::CL_PROG,
         psg_pkg::CL_SEQ:
            allow = ~busy_q & ~ph_q & wl_q & have_addr &
                    ~(eh_q & same_blk);
         psg_pkg::CL_ERASE: allow = idle & wl_q & have_addr;
         psg_pkg::CL_CHIP: allow = idle & wl_q;
         psg_pkg::CL_WRITE,
         psg_pkg::CL_NEVER: allow = idle;
         psg_pkg::CL_OTHER: allow = idle;
      endcase
   end

   assign accept      = frame_ok & allow;
   assign halt_accept = accept & (cls == psg_pkg::CL_HALT);
   assign go_accept   = accept & (cls == psg_pkg::CL_RESUME);

   always_comb begin
      run_new = psg_pkg::RUN_IDLE;
      unique case (cls)
         psg_pkg::CL_PROG: run_new = psg_pkg::RUN_PROG;
         psg_pkg::CL_ERASE: run_new = psg_pkg::RUN_ERASE;
         psg_pkg::CL_SEQ, psg_pkg::CL_CHIP,
         psg_pkg::CL_WRITE: run_new = psg_pkg::RUN_FIXED;
         default: run_new = psg_pkg::RUN_IDLE;
      endcase
   end

   assign starts_op = accept & (run_new != psg_pkg::RUN_IDLE);

   // ------------------------------------------------------------
   // Command hand-off to the array engine
   // ------------------------------------------------------------
   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         CMD_START_O  <= 1'b0;
         CMD_REJECT_O <= 1'b0;
         CMD_O        <= '0;
      end else begin
         CMD_START_O  <= accept & ~halt_accept & ~go_accept;
         CMD_REJECT_O <= frame_ok & ~allow;
         if (accept) begin
            CMD_O.opcode         <= op_q;
            CMD_O.addr           <= addr_q;
            CMD_O.undefined_data <= (cls == psg_pkg::CL_READ) &
               have_addr & ((ph_q & same_page) |
                            (eh_q & same_blk));
         end
      end
   end

   // ------------------------------------------------------------
   // Running operation tracking
   // ------------------------------------------------------------
   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         run_q      <= psg_pkg::RUN_IDLE;
         run_addr_q <= '0;
      end else if (starts_op) begin
         run_q      <= run_new;
         run_addr_q <= addr_q;
      end else if (go_accept) begin
         // Program first when both are held
         run_q      <= ph_q ? psg_pkg::RUN_PROG
                            : psg_pkg::RUN_ERASE;
         run_addr_q <= ph_q ? pgm_addr_q : ers_addr_q;
      end else if (OP_DONE_I || halt_done) begin
         run_q <= psg_pkg::RUN_IDLE;
      end
   end

   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         pgm_addr_q <= '0;
         ers_addr_q <= '0;
      end else if (halt_done) begin
         if (run_q == psg_pkg::RUN_PROG) begin
            pgm_addr_q <= run_addr_q;
         end else begin
            ers_addr_q <= run_addr_q;
         end
      end
   end

   // ------------------------------------------------------------
   // Suspend latency
   // ------------------------------------------------------------
   // A natural finish beats a late halt, so the op just ends
   assign halt_done = halt_pend_q & ~OP_DONE_I &
                      (HALT_ACK_I || halt_cnt_q == '0);

   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         halt_pend_q <= 1'b0;
         halt_cnt_q  <= '0;
         HALT_REQ_O  <= 1'b0;
      end else begin
         HALT_REQ_O <= halt_accept;
         if (halt_accept) begin
            halt_pend_q <= 1'b1;
            halt_cnt_q  <= CNT_W'(HALT_LAT_CYC - 1);
         end else if (halt_done || OP_DONE_I) begin
            halt_pend_q <= 1'b0;
         end else if (halt_pend_q) begin
            halt_cnt_q <= halt_cnt_q - 1'b1;
         end
      end
   end

   // ------------------------------------------------------------
   // Status flags
   // ------------------------------------------------------------
   always_comb begin
      ph_d = ph_q;
      eh_d = eh_q;
      if (go_accept) begin
         if (ph_q) begin
            ph_d = 1'b0;
         end else begin
            eh_d = 1'b0;
         end
      end
      if (halt_done && run_q == psg_pkg::RUN_PROG) begin
         ph_d = 1'b1;
      end
      if (halt_done && run_q == psg_pkg::RUN_ERASE) begin
         eh_d = 1'b1;
      end
   end

   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         ph_q  <= 1'b0;
         eh_q  <= 1'b0;
         sum_q <= 1'b0;
      end else begin
         ph_q  <= ph_d;
         eh_q  <= eh_d;
         sum_q <= ph_d | eh_d;
      end
   end

   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         busy_q <= 1'b0;
      end else if (starts_op || go_accept) begin
         busy_q <= 1'b1;
      end else if (OP_DONE_I || halt_done) begin
         busy_q <= 1'b0;
      end
   end

   // Latch clears when a write-type operation ends, not when halted
   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         wl_q <= 1'b0;
      end else if (accept && op_q == psg_pkg::OP_WLSET) begin
         wl_q <= 1'b1;
      end else if (accept && op_q == psg_pkg::OP_WLCLR) begin
         wl_q <= 1'b0;
      end else if (OP_DONE_I && busy_q) begin
         wl_q <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         RESUME_O       <= 1'b0;
         RESUME_ERASE_O <= 1'b0;
      end else begin
         RESUME_O <= go_accept;
         if (go_accept) begin
            RESUME_ERASE_O <= ~ph_q;
         end
      end
   end

   assign STATUS_O.device_busy_flag       = busy_q;
   assign STATUS_O.write_latch_flag       = wl_q;
   assign STATUS_O.program_suspended_flag = ph_q;
   assign STATUS_O.erase_suspended_flag   = eh_q;
   assign STATUS_O.suspend_summary_flag   = sum_q;

endmodule : psg_gate

// ### core/psg_pkg.sv
// Constants, types and opcode classes of the suspend gate
// What this block does
// - While busy, only suspend, status, terminate, reset, ID and wake pass.
// - Program held: reads, resume, latch, lock reads, OTP read, SFDP, wrap ok.
// - Erase held: reads, resume, latch, programs pass; no block or chip erase.
// - A program during erase hold must target another 64 kB block.
// - Status writes, locks, OTP program, power-down refused when busy or held.
// - Terminate, reset, ID, wake and status reads pass when busy or held.
// - Accepted suspend halts the operation, sets hold flags, clears busy.
// - No suspend of status write, lock, OTP program, chip erase or sequential.
// - A nested program must finish before the held erase can resume.
// - No erase starts while a program is held.
// - Suspend acts regardless of the write latch.
// - Suspend needs a whole opcode and a release on a byte boundary.
// - Reads into the held page or block return undefined data.
// - Resume clears the hold flag, and in the same cycle the summary if none held, sets busy.
// - With both held, resume restarts the program first, the erase later.
package psg_pkg;

   typedef logic [7:0] psg_op_t;

   localparam psg_op_t
      OP_RD0 = 8'h03, OP_RD1 = 8'h0B, OP_RD2 = 8'h3B,
      OP_RD3 = 8'h6B, OP_RD4 = 8'hEB, OP_RD5 = 8'hE7,
      OP_ER0 = 8'h20, OP_ER1 = 8'h52, OP_ER2 = 8'hD8,
      OP_CE0 = 8'h60, OP_CE1 = 8'hC7,
      OP_PG0 = 8'h02, OP_PG1 = 8'hA2, OP_PG2 = 8'h32,
      OP_SQ0 = 8'hAD, OP_SQ1 = 8'hAF,
      OP_HL0 = 8'hB0, OP_HL1 = 8'h75,
      OP_GO0 = 8'hD0, OP_GO1 = 8'h7A,
      OP_WLSET = 8'h06, OP_WLCLR = 8'h04, OP_VWL = 8'h50,
      OP_LK0 = 8'h36, OP_LK1 = 8'h39, OP_LK2 = 8'h7E, OP_LK3 = 8'h98,
      OP_LKR0 = 8'h3C, OP_LKR1 = 8'h3D,
      OP_OTPW = 8'h9B, OP_OTPR = 8'h4B,
      OP_ST0 = 8'h05, OP_ST1 = 8'h35, OP_ST2 = 8'h15, OP_ST3 = 8'h65,
      OP_SW0 = 8'h01, OP_SW1 = 8'h31, OP_SW2 = 8'h11, OP_SW3 = 8'h71,
      OP_STLK = 8'h6F,
      OP_TERM = 8'hF0, OP_RSEN = 8'h66, OP_RST = 8'h99,
      OP_ID0 = 8'h9F, OP_ID1 = 8'h90, OP_ID2 = 8'h94,
      OP_DPD = 8'hB9, OP_WAKE = 8'hAB, OP_UDPD = 8'h79,
      OP_SFDP = 8'h5A, OP_WRAP = 8'h77;

   localparam int ADDR_W   = 24;
   localparam int BLK_LSB  = 16;
   localparam int PAGE_LSB = 8;
   localparam logic [2:0] BYTES_ADDR = 3'h4;
   localparam logic [2:0] BIT_LAST   = 3'h7;

   localparam int CLK_MHZ            = 250;
   localparam int HALT_LATENCY_US    = 20;

   typedef struct packed {
      logic device_busy_flag;
      logic write_latch_flag;
      logic program_suspended_flag;
      logic erase_suspended_flag;
      logic suspend_summary_flag;
   } psg_flags_s;

   typedef struct packed {
      psg_op_t             opcode;
      logic [ADDR_W-1:0]   addr;
      logic                undefined_data;
   } psg_cmd_s;

   typedef enum logic [1:0] {
      RUN_IDLE, RUN_PROG, RUN_ERASE, RUN_FIXED
   } psg_run_e;

   typedef enum logic [3:0] {
      CL_ALWAYS, CL_HALT, CL_RESUME, CL_READ, CL_HELDOK, CL_WLAT,
      CL_PROG, CL_SEQ, CL_ERASE, CL_CHIP, CL_WRITE, CL_NEVER,
      CL_OTHER
   } psg_class_e;

endpackage : psg_pkg

// ### tb/program_erase_suspend_gate_test.sv
// Self-checking bench for the suspend gate
`timescale 1ns/10ps
module program_erase_suspend_gate_test;
   // ---------------------------------------------
   // Signals, design, host and monitor
   // ---------------------------------------------
   logic clk, rst_n, cs_n, sck, si, op_done, halt_ack;
   logic cmd_start, cmd_reject, halt_req, resume, resume_erase;
   psg_pkg::psg_cmd_s   cmd;
   psg_pkg::psg_flags_s status;
   logic [2:0] ev;
   int n_errors = 0;
   int compares = 0;

   psg_gate #(.HALT_LAT_CYC(40)) dut (
      .CLK_I(clk), .RST_N_I(rst_n), .SPI_CS_N_I(cs_n), .SPI_SCK_I(sck),
      .SPI_SI_I(si), .OP_DONE_I(op_done), .HALT_ACK_I(halt_ack),
      .CMD_START_O(cmd_start), .CMD_O(cmd), .CMD_REJECT_O(cmd_reject),
      .HALT_REQ_O(halt_req), .RESUME_O(resume),
      .RESUME_ERASE_O(resume_erase), .STATUS_O(status));
   psg_host host (.clk_i(clk), .cs_n_o(cs_n), .sck_o(sck), .si_o(si));

   // Answer codes: 1 start, 2 refuse, 3 halt, 4 resume, 0 none
   always @(posedge clk) begin
      if (cmd_start) ev = 3'h1;
      if (cmd_reject) ev = 3'h2;
      if (halt_req) ev = 3'h3;
      if (resume) ev = 3'h4;
   end

   initial begin
      clk = 1'h0;
      forever #2 clk = ~clk;
   end

   // ---------------------------------------------
   // Shared tasks
   // ---------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t: got %0h expected %0h", $time, got,
                  exp);
      end
   endtask : chk
   task automatic send(input logic [31:0] w, input int n, input logic [2:0] e);
      @(negedge clk) ev = 3'h0;
      host.frame(w, n);
      chk(32'(ev), 32'(e));
   endtask : send
   task automatic flags(input logic [4:0] e);
      chk(32'(status), 32'(e));
   endtask : flags
   // Engine pulse: 1 for operation done, 0 for halt acknowledge
   task automatic pulse(input logic done);
      @(negedge clk) if (done) op_done = 1'h1; else halt_ack = 1'h1;
      @(negedge clk) op_done = 1'h0;
      halt_ack = 1'h0;
      repeat (2) @(negedge clk);
   endtask : pulse
   task automatic conclude();
      $display("errors %0d compares %0d", n_errors, compares);
      if (n_errors == 0 && compares > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : conclude

   // ---------------------------------------------
   // Scenarios
   // ---------------------------------------------
   task automatic t_busy();
      logic [7:0] ok[$] = '{8'hF0, 8'h66, 8'h99, 8'h9F, 8'h90, 8'h94,
                            8'hAB, 8'h05, 8'h35, 8'h15, 8'h65};
      logic [7:0] no[$] = '{8'h03, 8'h20, 8'hC7, 8'h02, 8'hAF, 8'hD0,
                            8'h06, 8'h50, 8'h36, 8'h9B, 8'h01, 8'h6F,
                            8'hB9, 8'h79, 8'h5A, 8'h77};
      send(32'h0600_0000, 8, 3'h1);
      send(32'h0212_0000, 32, 3'h1);
      chk({cmd.opcode, cmd.addr}, 32'h0212_0000);
      flags(5'h18);
      foreach (ok[i]) send({ok[i], 24'h0}, 8, 3'h1);
      foreach (no[i]) begin
         send({no[i], 24'h0}, 32, 3'h2);
         flags(5'h18);
      end
      send(32'hB000_0000, 7, 3'h0);
      send(32'hB000_0000, 8, 3'h3);
      pulse(1'h0);
      flags(5'h0D);
   endtask : t_busy
   task automatic t_prog_held();
      logic [7:0] ok[$] = '{8'h03, 8'h04, 8'h50, 8'h3C, 8'h4B, 8'h5A,
                            8'h77, 8'h06};
      logic [7:0] no[$] = '{8'h02, 8'hA2, 8'hAD, 8'h20, 8'h52, 8'hD8,
                            8'hC7, 8'h9B, 8'h01, 8'h98, 8'hB9, 8'hB0};
      foreach (ok[i]) send({ok[i], 24'h0}, 8, 3'h1);
      foreach (no[i]) begin
         send({no[i], 24'h0}, 32, 3'h2);
         flags(5'h0D);
      end
      send(32'h0312_00FF, 32, 3'h1);
      chk(32'(cmd.undefined_data), 32'h1);
      send(32'h0312_0100, 32, 3'h1);
      chk(32'(cmd.undefined_data), 32'h0);
      send(32'h7A00_0000, 8, 3'h4);
      chk(32'(resume_erase), 32'h0);
      flags(5'h18);
      pulse(1'h1);
      flags(5'h00);
   endtask : t_prog_held
   task automatic t_erase_held();
      send(32'h0600_0000, 8, 3'h1);
      send(32'hD805_0000, 32, 3'h1);
      send(32'h7500_0000, 8, 3'h3);
      repeat (40) @(negedge clk);
      flags(5'h0B);
      send(32'h2007_0000, 32, 3'h2);
      send(32'hC700_0000, 8, 3'h2);
      send(32'h0305_0010, 32, 3'h1);
      chk(32'(cmd.undefined_data), 32'h1);
      send(32'h0205_1000, 32, 3'h2);
      flags(5'h0B);
      send(32'h0206_0000, 32, 3'h1);
      flags(5'h1B);
      send(32'hD000_0000, 8, 3'h2);
      send(32'hB000_0000, 8, 3'h3);
      pulse(1'h0);
      flags(5'h0F);
      send(32'h7A00_0000, 8, 3'h4);
      chk(32'(resume_erase), 32'h0);
      flags(5'h1B);
      pulse(1'h1);
      flags(5'h03);
      send(32'hD000_0000, 8, 3'h4);
      chk(32'(resume_erase), 32'h1);
      flags(5'h10);
      send(32'hB000_0000, 8, 3'h3);
      pulse(1'h0);
      flags(5'h03);
      send(32'hD000_0000, 8, 3'h4);
      pulse(1'h1);
      flags(5'h00);
   endtask : t_erase_held
   task automatic t_fixed();
      send(32'h0600_0000, 8, 3'h1);
      send(32'hC700_0000, 8, 3'h1);
      send(32'hB000_0000, 8, 3'h2);
      send(32'h7500_0000, 8, 3'h2);
      flags(5'h18);
      pulse(1'h1);
      flags(5'h00);
      send(32'h0100_0000, 8, 3'h1);
      send(32'hB000_0000, 8, 3'h2);
      pulse(1'h1);
      flags(5'h00);
      // A finish during a pending halt just ends the program
      send(32'h0600_0000, 8, 3'h1);
      send(32'h0203_0000, 32, 3'h1);
      send(32'hB000_0000, 8, 3'h3);
      pulse(1'h1);
      flags(5'h00);
   endtask : t_fixed

   // ---------------------------------------------
   // Main sequence and watchdog
   // ---------------------------------------------
   initial begin
      rst_n = 1'h0;
      op_done = 1'h0;
      halt_ack = 1'h0;
      ev = 3'h0;
      repeat (20) @(negedge clk);
      rst_n = 1'h1;
      repeat (5) @(negedge clk);
      t_busy();
      t_prog_held();
      t_erase_held();
      t_fixed();
      conclude();
   end
   // Well above the longest expected run of some 65000 cycles
   initial begin
      repeat (90000) @(posedge clk);
      n_errors++;
      conclude();
   end
endmodule : program_erase_suspend_gate_test

// ### tb/psg_host.sv
// SPI host model that sends one command frame at a time
`timescale 1ns/10ps
module psg_host (
   // Clock for pacing
   input  wire logic clk_i,
   // SPI pins
   output logic      cs_n_o,
   output logic      sck_o,
   output logic      si_o
);
   // ---------------------------------------------
   // Frame driver, mode 0, clock still outside frames
   // ---------------------------------------------
   localparam int HALF = 20;
   initial begin
      cs_n_o = 1'h1;
      sck_o  = 1'h0;
      si_o   = 1'h0;
   end
   // Sends the top nbits of w, MSB first, one bit per link clock
   task automatic frame(input logic [31:0] w, input int nbits);
      @(negedge clk_i) cs_n_o = 1'h0;
      repeat (HALF) @(negedge clk_i);
      for (int i = 0; i < nbits; i++) begin
         si_o = w[31-i];
         repeat (HALF) @(negedge clk_i);
         sck_o = 1'h1;
         repeat (HALF) @(negedge clk_i);
         sck_o = 1'h0;
      end
      repeat (HALF) @(negedge clk_i);
      cs_n_o = 1'h1;
      // Released line carries no valid bit, so show the inverse
      si_o = ~si_o;
      repeat (HALF) @(negedge clk_i);
   endtask : frame
endmodule : psg_host

// ### tb/psg_properties.sv
// Port checker for the suspend gate, bound to psg_gate
`timescale 1ns/10ps
module psg_properties #(
   parameter int unsigned HALT_LAT_CYC =
      psg_pkg::HALT_LATENCY_US * psg_pkg::CLK_MHZ
) (
   // Clock, reset and engine
   input wire logic                CLK_I,
   input wire logic                RST_N_I,
   input wire logic                OP_DONE_I,
   input wire logic                HALT_ACK_I,
   // Answers and flags
   input wire logic                CMD_START_O,
   input wire psg_pkg::psg_cmd_s   CMD_O,
   input wire logic                CMD_REJECT_O,
   input wire logic                HALT_REQ_O,
   input wire logic                RESUME_O,
   input wire logic                RESUME_ERASE_O,
   input wire psg_pkg::psg_flags_s STATUS_O
);
   // ---------------------------------------------
   // Helpers and properties
   // ---------------------------------------------
   localparam int HALT_MAX = HALT_LAT_CYC + 2;
   logic busy, pheld, eheld, held, idle;
   assign busy  = STATUS_O.device_busy_flag;
   assign pheld = STATUS_O.program_suspended_flag;
   assign eheld = STATUS_O.erase_suspended_flag;
   assign held  = pheld | eheld;
   assign idle  = !busy && !held;
   // Cycles since a halt request while still busy; a range would be too long
   logic [15:0] halt_age_q;
   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         halt_age_q <= '0;
      end else if (HALT_REQ_O) begin
         halt_age_q <= 16'h0001;
      end else if (halt_age_q != '0 && busy) begin
         halt_age_q <= halt_age_q + 16'h0001;
      end else begin
         halt_age_q <= '0;
      end
   end
   default clocking @(posedge CLK_I); endclocking
   default disable iff (!RST_N_I);

   one_answer_a: assert property (
      $onehot0({CMD_START_O, CMD_REJECT_O, HALT_REQ_O, RESUME_O}))
      else $error("more than one answer in a cycle");
   busy_gate_a: assert property (CMD_START_O && $past(busy) |->
      CMD_O.opcode inside {8'hF0, 8'h66, 8'h99, 8'h9F, 8'h90, 8'h94,
                           8'hAB, 8'h05, 8'h35, 8'h15, 8'h65})
      else $error("command started while busy");
   locked_cmds_a: assert property (CMD_START_O && CMD_O.opcode inside
      {8'h01, 8'h31, 8'h11, 8'h71, 8'h6F, 8'h36, 8'h39, 8'h7E, 8'h98,
       8'h9B, 8'hB9, 8'h79} |-> $past(idle))
      else $error("locked command started outside idle");
   no_erase_held_a: assert property (CMD_START_O && CMD_O.opcode inside
      {8'h20, 8'h52, 8'hD8, 8'h60, 8'hC7} |-> !$past(pheld))
      else $error("erase started with program held");
   halt_busy_a: assert property (HALT_REQ_O |-> $past(busy))
      else $error("halt request while not busy");
   halt_bound_a: assert property (halt_age_q <= 16'(HALT_MAX))
      else $error("halt not reached in time");
   hold_flags_a: assert property ($rose(STATUS_O.suspend_summary_flag)
      |-> $fell(busy)) else $error("summary set without busy clear");
   summary_a: assert property (STATUS_O.suspend_summary_flag == held)
      else $error("summary flag differs from hold flags");
   resume_gate_a: assert property (RESUME_O |->
      !$past(busy) && $past(held) && busy)
      else $error("resume outside held state");
   program_first_a: assert property (RESUME_O && $past(pheld) |->
      !RESUME_ERASE_O && !pheld && eheld == $past(eheld))
      else $error("erase resumed before held program");
   reject_still_a: assert property (CMD_REJECT_O && !$past(OP_DONE_I)
      && !$past(HALT_ACK_I) |-> $stable(STATUS_O))
      else $error("refused command changed flags");
endmodule : psg_properties

bind psg_gate psg_properties #(.HALT_LAT_CYC(HALT_LAT_CYC)) u_props (
   .CLK_I(CLK_I), .RST_N_I(RST_N_I), .OP_DONE_I(OP_DONE_I),
   .HALT_ACK_I(HALT_ACK_I), .CMD_START_O(CMD_START_O), .CMD_O(CMD_O),
   .CMD_REJECT_O(CMD_REJECT_O), .HALT_REQ_O(HALT_REQ_O),
   .RESUME_O(RESUME_O), .RESUME_ERASE_O(RESUME_ERASE_O),
   .STATUS_O(STATUS_O));
